/* File: hw/spd_defines.svh */
// constants of the serial process data port: device map, command codes,
// configuration bit positions, host register map
// assumes: included by bare name from the device, host and bench files
`ifndef SPD_DEFINES_SVH
`define SPD_DEFINES_SVH

// ----------------------------------------------------------------------
// device register map
// ----------------------------------------------------------------------
`define SPD_REG_PORT_TYPE 16'h0140
`define SPD_REG_SERIAL_CFG 16'h0150
`define SPD_REG_EVENT_LOW 16'h0220
`define SPD_REG_EVENT_MID 16'h0221
`define SPD_REG_EVENT_HIGH 16'h0222
`define SPD_PORT_TYPE_SERIAL 8'h05

// ----------------------------------------------------------------------
// serial configuration bits (device cfg, host cfg low byte)
// ----------------------------------------------------------------------
`define SPD_CFG_CPHA 0
`define SPD_CFG_CPOL 1
`define SPD_CFG_LATE 2
`define SPD_CFG_SEL_HIGH 3
`define SPD_CFG_IRQ_HIGH 4

// ----------------------------------------------------------------------
// command codes and framing
// ----------------------------------------------------------------------
`define SPD_CMD_NOP 3'h0
`define SPD_CMD_READ 3'h2
`define SPD_CMD_READ_WS 3'h3
`define SPD_CMD_WRITE 3'h4
`define SPD_CMD_EXT 3'h6
`define SPD_WAIT_BYTE 8'hff
`define SPD_LAST_BIT 3'h7
`define SPD_ADDR2_TOP 3'h0

// ----------------------------------------------------------------------
// host register map (apb byte offsets)
// ----------------------------------------------------------------------
`define SPD_HOST_CFG 8'h00
`define SPD_HOST_SEL 8'h04
`define SPD_HOST_TX 8'h08
`define SPD_HOST_RX 8'h0c
`define SPD_HOST_DIV_LSB 8
`define SPD_HOST_DIV_DEFAULT 8'h08
`define SPD_HOST_LAST_HALF 5'h0f

`endif

/* File: hw/spd_device.sv */
// serial slave end of the process data port: byte access to the 16-bit
// internal space, event bytes shifted out during the address phase
// assumes: pins asynchronous to clk; memory answers memRead by memRvalid
//
// Functional notes
// - active only when port type selects serial
// - mode and polarities from serial configuration
// - address phase of two or three bytes
// - any data byte count, address increments
// - master frames access with select
// - master gives eight clocks per byte
// - one bit each way per clock
// - edges chosen by clock phase and polarity
// - msb first, low byte first
// - two-byte mode forces top bits zero
// - three-byte mode gives full sixteen bits
// - two-byte layout: address, command, data
// - three-byte layout with extension and command
// - decode nop, read, read-wait, write, extension
// - extra extension bytes lengthen address phase
// - event request bytes out during address
// - five link signals
// - config-loaded high once port active
// - master waits or sends one wait byte
// - all-ones byte ends read, else prefetch
// - four access error cases flagged
// - status level before first clock edge
`timescale 1ns/1ns
`include "spd_defines.svh"
module spd_device (
    input wire logic clk,
    input wire logic srst,
    input wire logic ce,
    spd_if.device link,
    input wire logic [7:0] portType,
    input wire logic [7:0] serialCfg,
    input wire logic cfgMemLoaded,
    input wire logic [23:0] eventRequest,
    input wire logic [23:0] eventMask,
    output logic [15:0] memAddr,
    output logic [7:0] memWdata,
    output logic memWrite,
    output logic memRead,
    input wire logic [7:0] memRdata,
    input wire logic memRvalid,
    output logic accessError
);

    spd_pkg::spd_dev_state_t st;
    spd_pkg::spd_dev_state_t n;

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    function automatic logic [7:0] outByte(input spd_pkg::spd_phase_t ph,
                                           input logic [23:0] ev,
                                           input logic [7:0] buf8);
        unique case (ph)
            spd_pkg::PH_ADDR0: outByte = ev[7:0];
            spd_pkg::PH_ADDR1: outByte = ev[15:8];
            spd_pkg::PH_EXT: outByte = ev[23:16];
            spd_pkg::PH_READ: outByte = buf8;
            default: outByte = `SPD_WAIT_BYTE;
        endcase
    endfunction : outByte

    logic active;
    logic selNow;
    logic rise;
    logic fall;
    logic sampleE;
    logic shiftE;
    logic din;
    logic statusAvail;
    logic [7:0] byteIn;
    logic [7:0] bufNow;
    logic cmdHit;
    logic [2:0] cmd;
    logic [15:0] newAddr;
    logic err;

    // ------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------
    always_comb begin
        n = st;
        byteIn = {st.shiftIn[6:0], st.dinSync[1]};
        cmdHit = 1'b0;
        cmd = `SPD_CMD_NOP;
        newAddr = st.addr;
        err = 1'b0;
        n.memWrite = 1'b0;
        n.memRead = 1'b0;
        n.accessError = 1'b0;
        n.selSync = {st.selSync[1:0], link.sel};
        n.clkSync = {st.clkSync[1:0], link.sclk};
        n.dinSync = {st.dinSync[0], link.mosi};
        active = (portType == `SPD_PORT_TYPE_SERIAL) && cfgMemLoaded;
        selNow = active && (st.selSync[1] == serialCfg[`SPD_CFG_SEL_HIGH]);
        rise = st.clkSync[1] & ~st.clkSync[2];
        fall = ~st.clkSync[1] & st.clkSync[2];
        if (serialCfg[`SPD_CFG_CPHA] ^ serialCfg[`SPD_CFG_CPOL]) begin
            sampleE = fall;
            shiftE = rise;
        end else begin
            sampleE = rise;
            shiftE = fall;
        end
        din = st.dinSync[1];
        statusAvail = serialCfg[`SPD_CFG_CPHA] | serialCfg[`SPD_CFG_LATE];
        bufNow = memRvalid ? memRdata : st.dataBuf;
        if (memRvalid) begin
            n.dataBuf = memRdata;
            n.fetchBusy = 1'b0;
            n.firstFetch = 1'b0;
            // first byte ready after the wait
            if (st.firstFetch && st.phase == spd_pkg::PH_READ &&
                    !st.loadPending) begin
                n.shiftOut = memRdata;
            end
        end
        if (!st.selected && selNow) begin
            n.selected = 1'b1;
            n.seenEdge = 1'b0;
            n.bitCnt = '0;
            n.phase = spd_pkg::PH_ADDR0;
            n.loadPending = serialCfg[`SPD_CFG_CPHA];
            n.shiftOut = outByte(spd_pkg::PH_ADDR0, eventRequest, bufNow);
            n.errAcc = 1'b0;
            n.sawData = 1'b0;
            n.dinLow = 1'b0;
        end else if (st.selected && !selNow) begin
            n.selected = 1'b0;
            if (st.seenEdge) begin
                err = st.errAcc || (st.bitCnt != '0) ||
                      (st.phase == spd_pkg::PH_READ && st.sawData);
                n.statusOk = !err;
                n.accessError = err;
            end
        end else if (st.selected) begin
            if (sampleE || shiftE) begin
                n.seenEdge = 1'b1;
                if (st.firstFetch && st.fetchBusy) begin
                    n.errAcc = 1'b1;
                end
            end
            if (shiftE) begin
                if (st.loadPending) begin
                    n.shiftOut = outByte(st.phase, eventRequest, bufNow);
                    n.loadPending = 1'b0;
                end else begin
                    n.shiftOut = {st.shiftOut[6:0], 1'b1};
                end
            end
            if (sampleE) begin
                n.shiftIn = byteIn;
                n.bitCnt = st.bitCnt + 3'h1;
                if (!din) begin
                    n.dinLow = 1'b1;
                end
                if (!din && !st.dinLow && st.phase == spd_pkg::PH_READ &&
                        st.bitCnt != `SPD_LAST_BIT && !st.fetchBusy) begin
                    n.memRead = 1'b1;
                    n.memAddr = st.addr;
                    n.addr = st.addr + 16'h0001;
                    n.fetchBusy = 1'b1;
                end
                if (st.bitCnt == `SPD_LAST_BIT) begin
                    n.loadPending = 1'b1;
                    n.dinLow = 1'b0;
                    unique case (st.phase)
                        spd_pkg::PH_ADDR0: begin
                            n.addr[12:5] = byteIn;
                            n.phase = spd_pkg::PH_ADDR1;
                        end
                        spd_pkg::PH_ADDR1: begin
                            newAddr = {`SPD_ADDR2_TOP, st.addr[12:5],
                                       byteIn[7:3]};
                            cmd = byteIn[2:0];
                            cmdHit = 1'b1;
                        end
                        spd_pkg::PH_EXT: begin
                            newAddr = {byteIn[7:5], st.addr[12:0]};
                            cmd = byteIn[4:2];
                            cmdHit = 1'b1;
                        end
                        spd_pkg::PH_WAIT: n.phase = spd_pkg::PH_READ;
                        spd_pkg::PH_READ: begin
                            n.sawData = 1'b1;
                            if (!st.dinLow && din) begin
                                n.phase = spd_pkg::PH_DONE;
                            end
                        end
                        spd_pkg::PH_DONE: n.errAcc = 1'b1;
                        spd_pkg::PH_WRITE: begin
                            n.memWrite = 1'b1;
                            n.memAddr = st.addr;
                            n.memWdata = byteIn;
                            n.addr = st.addr + 16'h0001;
                        end
                        spd_pkg::PH_IGNORE: n.phase = spd_pkg::PH_IGNORE;
                    endcase
                end
            end
        end
        if (cmdHit) begin
            n.addr = newAddr;
            unique case (cmd)
                `SPD_CMD_EXT: n.phase = spd_pkg::PH_EXT;
                `SPD_CMD_READ, `SPD_CMD_READ_WS: begin
                    n.memRead = 1'b1;
                    n.memAddr = newAddr;
                    n.addr = newAddr + 16'h0001;
                    n.fetchBusy = 1'b1;
                    n.firstFetch = 1'b1;
                    n.phase = (cmd == `SPD_CMD_READ_WS) ?
                              spd_pkg::PH_WAIT : spd_pkg::PH_READ;
                end
                `SPD_CMD_WRITE: n.phase = spd_pkg::PH_WRITE;
                default: n.phase = spd_pkg::PH_IGNORE;
            endcase
        end
        n.miso = (n.selected && !n.seenEdge && statusAvail) ?
                 n.statusOk : n.shiftOut[7];
        n.irq = (active && |(eventRequest & eventMask)) ~^
                serialCfg[`SPD_CFG_IRQ_HIGH];
        n.cfgLoaded = active;
    end

    // ------------------------------------------------------------------
    // state register
    // ------------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (srst) begin
            st <= '0;
            st.selSync <= '1;
            st.statusOk <= 1'b1;
            st.miso <= 1'b1;
            st.irq <= 1'b1;
        end else if (ce) begin
            st <= n;
        end
    end

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    // three link signals driven by the device
    assign link.miso = st.miso;
    assign link.irq = st.irq;
    assign link.cfgLoaded = st.cfgLoaded;
    assign memAddr = st.memAddr;
    assign memWdata = st.memWdata;
    assign memWrite = st.memWrite;
    assign memRead = st.memRead;
    assign accessError = st.accessError;

endmodule : spd_device

/* File: hw/spd_host.sv */
// serial master end: apb-programmed byte engine that frames accesses,
// makes the serial clock by a divider and samples the returned data
// assumes: software builds address, command, wait and data bytes
`timescale 1ns/1ns
`include "spd_defines.svh"
module spd_host (
    input wire logic clk,
    input wire logic srst,
    input wire logic ce,
    input wire logic [7:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    spd_if.host link
);

    spd_pkg::spd_host_state_t st;
    spd_pkg::spd_host_state_t n;

    logic cpha;
    logic cpol;
    logic leading;
    logic sampleE;
    logic shiftE;
    logic [7:0] div;

    // ------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------
    always_comb begin
        n = st;
        n.misoSync = {st.misoSync[0], link.miso};
        n.irqSync = {st.irqSync[0], link.irq};
        n.loadSync = {st.loadSync[0], link.cfgLoaded};
        cpha = st.cfg[`SPD_CFG_CPHA];
        cpol = st.cfg[`SPD_CFG_CPOL];
        div = st.cfg[`SPD_HOST_DIV_LSB +: 8];
        leading = !st.half[0];
        sampleE = 1'b0;
        shiftE = 1'b0;
        // register reads prepared in the setup cycle
        if (psel && !penable) begin
            n.pslverr = 1'b0;
            unique case (paddr)
                `SPD_HOST_CFG: n.prdata = {16'h0000, st.cfg};
                `SPD_HOST_SEL: n.prdata = {31'h00000000, st.selAssert};
                `SPD_HOST_RX: n.prdata = {20'h00000, st.misoSync[1],
                    st.loadSync[1], st.irqSync[1],
                    st.mode == spd_pkg::HM_SHIFT, st.rx};
                `SPD_HOST_TX: n.prdata = {24'h000000, st.txShift};
                default: begin
                    n.prdata = 32'h00000000;
                    n.pslverr = 1'b1;
                end
            endcase
        end
        if (psel && penable && pwrite) begin
            unique case (paddr)
                `SPD_HOST_CFG: n.cfg = pwdata[15:0];
                `SPD_HOST_SEL: n.selAssert = pwdata[0];
                `SPD_HOST_TX: begin
                    if (st.mode == spd_pkg::HM_IDLE) begin
                        n.txShift = pwdata[7:0];
                        n.mode = spd_pkg::HM_SHIFT;
                        n.divCnt = 8'h00;
                        n.half = 5'h00;
                        n.firstShift = 1'b1;
                    end
                end
                default: n.mode = st.mode;
            endcase
        end
        if (st.mode == spd_pkg::HM_SHIFT) begin
            if (st.divCnt == div - 8'h01) begin
                n.divCnt = 8'h00;
                n.sclk = ~st.sclk;
                n.half = st.half + 5'h01;
                sampleE = cpha ? !leading : leading;
                shiftE = !sampleE;
                if (sampleE) begin
                    n.rx = {st.rx[6:0], st.misoSync[1]};
                end
                if (shiftE) begin
                    if (st.firstShift && cpha) begin
                        n.firstShift = 1'b0;
                    end else begin
                        n.txShift = {st.txShift[6:0], 1'b1};
                    end
                end
                if (st.half == `SPD_HOST_LAST_HALF) begin
                    n.mode = spd_pkg::HM_IDLE;
                end
            end else begin
                n.divCnt = st.divCnt + 8'h01;
            end
        end else begin
            n.sclk = cpol;
        end
    end

    // ------------------------------------------------------------------
    // state register
    // ------------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (srst) begin
            st <= '0;
            st.cfg <= {`SPD_HOST_DIV_DEFAULT, 8'h00};
            st.txShift <= `SPD_WAIT_BYTE;
        end else if (ce) begin
            st <= n;
        end
    end

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    assign link.sel = st.selAssert ~^ st.cfg[`SPD_CFG_SEL_HIGH];
    assign link.sclk = st.sclk;
    assign link.mosi = st.txShift[7];
    assign prdata = st.prdata;
    assign pslverr = st.pslverr & psel & penable;
    assign pready = psel & penable;

endmodule : spd_host

/* File: hw/spd_if.sv */
// link between serial host and device: five pins plus config-loaded
// assumes: bench joins both ends through this interface
`timescale 1ns/1ns
interface spd_if;
    logic sel;
    logic sclk;
    logic mosi;
    logic miso;
    logic irq;
    logic cfgLoaded;

    modport device (input sel, input sclk, input mosi,
                    output miso, output irq, output cfgLoaded);
    modport host (output sel, output sclk, output mosi,
                  input miso, input irq, input cfgLoaded);
endinterface : spd_if

/* File: hw/spd_pkg.sv */
// types of the serial process data port: phases and state records
// assumes: nothing beyond the language
package spd_pkg;

    typedef enum logic [2:0] {
        PH_ADDR0, PH_ADDR1, PH_EXT, PH_WAIT,
        PH_READ, PH_DONE, PH_WRITE, PH_IGNORE
    } spd_phase_t;

    typedef enum logic {HM_IDLE, HM_SHIFT} spd_host_mode_t;

    typedef struct packed {
        logic [2:0] selSync;
        logic [2:0] clkSync;
        logic [1:0] dinSync;
        logic selected;
        logic seenEdge;
        logic [2:0] bitCnt;
        logic [7:0] shiftIn;
        logic [7:0] shiftOut;
        logic loadPending;
        logic dinLow;
        spd_phase_t phase;
        logic [15:0] addr;
        logic [7:0] dataBuf;
        logic fetchBusy;
        logic firstFetch;
        logic sawData;
        logic errAcc;
        logic statusOk;
        logic miso;
        logic irq;
        logic cfgLoaded;
        logic [15:0] memAddr;
        logic [7:0] memWdata;
        logic memWrite;
        logic memRead;
        logic accessError;
    } spd_dev_state_t;

    typedef struct packed {
        logic [1:0] misoSync;
        logic [1:0] irqSync;
        logic [1:0] loadSync;
        logic [15:0] cfg;
        logic selAssert;
        logic sclk;
        spd_host_mode_t mode;
        logic [7:0] divCnt;
        logic [4:0] half;
        logic firstShift;
        logic [7:0] txShift;
        logic [7:0] rx;
        logic [31:0] prdata;
        logic pslverr;
    } spd_host_state_t;

endpackage : spd_pkg

/* File: verif/spd_link_sva.sv */
// checker: pin relations on the link between host and device
// assumes: mode 0, select active low, host divider 8
`timescale 1ns/1ns
module spd_link_sva #(
    parameter logic SEL_ACT = 1'b0
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic sel,
    input wire logic sclk,
    input wire logic mosi,
    input wire logic miso,
    input wire logic irq,
    input wire logic cfgLoaded
);
    logic act;
    logic sclkQ;
    logic [3:0] tog;
    assign act = (sel == SEL_ACT);
    // counts clock toggles inside one select window
    always_ff @(posedge clk) begin
        sclkQ <= sclk;
        if (srst || !act) begin
            tog <= 4'h0;
        end else if (sclk != sclkQ) begin
            tog <= tog + 4'h1;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);
    chk_sclk_half: assert property ($changed(sclk) |=> $stable(sclk)[*7])
        else $error("sclk half period short");
    chk_sclk_framed: assert property ($changed(sclk) |-> act)
        else $error("sclk moved while deselected");
    chk_sclk_idle: assert property (!act |-> sclk == 1'b0)
        else $error("sclk not idle low");
    chk_whole_bytes: assert property ($changed(sel) && !act |-> tog == 4'h0)
        else $error("partial byte at deselect");
    chk_mosi_hold: assert property ($rose(sclk) |=> $stable(mosi)[*4])
        else $error("mosi moved after sample edge");
    chk_miso_setup: assert property ($rose(sclk) |-> $stable(miso)[*4])
        else $error("miso moved at sample edge");
    chk_sel_clean: assert property ($changed(sel) |-> !sclk && $stable(sclk))
        else $error("select moved with clock active");
    chk_loaded_quiet: assert property ($changed(cfgLoaded) |-> !act)
        else $error("loaded flag moved in access");
    cov_frame: cover property (act ##1 !act);
    cov_irq: cover property ($rose(irq));
    cov_off: cover property ($fell(cfgLoaded));
endmodule : spd_link_sva

/* File: verif/spd_tb.sv */
// bench: apb drives the host, host meets device over the link
// assumes: design files compiled first; memory modelled here
`timescale 1ns/1ns
`include "spd_defines.svh"
module spd_tb;
    logic clk, srst, psel, penable, pwrite, pready, pslverr, perr;
    logic memWrite, memRead, memRvalid, accessError, cfgMemLoaded;
    logic [7:0] paddr, portType, serialCfg, memWdata, memRdata;
    logic [31:0] pwdata, prdata, r;
    logic [15:0] memAddr;
    logic [23:0] evMask;
    logic [7:0] mem [0:65535];
    logic [7:0] txb [0:7];
    logic [7:0] rxb [0:7];
    int mismatches, samples_checked, wrCnt, errCnt;
    localparam logic [23:0] EV = 24'hc35aa5;
    spd_if lnk ();
    spd_device u_spd_device (.clk(clk), .srst(srst), .ce(1'b1), .link(lnk),
        .portType(portType), .serialCfg(serialCfg),
        .cfgMemLoaded(cfgMemLoaded), .eventRequest(EV), .eventMask(evMask),
        .memAddr(memAddr), .memWdata(memWdata), .memWrite(memWrite),
        .memRead(memRead), .memRdata(memRdata), .memRvalid(memRvalid),
        .accessError(accessError));
    spd_host u_spd_host (.clk(clk), .srst(srst), .ce(1'b1), .paddr(paddr),
        .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .link(lnk));
    spd_link_sva #(.SEL_ACT(1'b0)) u_spd_link_sva (.clk(clk), .srst(srst),
        .sel(lnk.sel), .sclk(lnk.sclk), .mosi(lnk.mosi), .miso(lnk.miso),
        .irq(lnk.irq), .cfgLoaded(lnk.cfgLoaded));
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    always @(posedge clk) begin
        memRvalid <= memRead;
        memRdata <= mem[memAddr];
        if (memWrite === 1'b1) begin
            mem[memAddr] <= memWdata;
            wrCnt <= wrCnt + 1;
        end
        if (accessError === 1'b1) begin
            errCnt <= errCnt + 1;
        end
    end
    function automatic logic [7:0] md(input logic [15:0] a);
        return a[7:0] ^ a[15:8];
    endfunction : md
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : end_of_test
    task automatic check(input logic ok, input string m);
        samples_checked++;
        if (ok !== 1'b1) begin
            mismatches++;
            $display("BAD %0t %s", $time, m);
        end
    endtask : check
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        r = prdata;
        perr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask : apb
    task automatic run(input int n);
        apb(1'b1, `SPD_HOST_SEL, 32'h1);
        for (int i = 0; i < n; i++) begin
            apb(1'b1, `SPD_HOST_TX, {24'h0, txb[i]});
            do apb(1'b0, `SPD_HOST_RX, 32'h0); while (r[8] !== 1'b0);
            rxb[i] = r[7:0];
        end
        apb(1'b1, `SPD_HOST_SEL, 32'h0);
        repeat (8) @(posedge clk);
    endtask : run
    task automatic hdr(input logic [15:0] a, input logic [2:0] c);
        txb[0] = a[12:5];
        txb[1] = {a[4:0], c};
    endtask : hdr
    task automatic t_write();
        int e0;
        e0 = errCnt;
        hdr(16'h0345, `SPD_CMD_WRITE);
        txb[2] = 8'h11;
        txb[3] = 8'h22;
        run(4);
        check(rxb[0] === EV[7:0] && rxb[1] === EV[15:8], "event");
        check(mem[16'h0345] === 8'h11, "write byte 0");
        check(mem[16'h0346] === 8'h22, "write byte 1");
        check(errCnt == e0, "write flagged");
    endtask : t_write
    task automatic t_ext();
        int e0;
        e0 = errCnt;
        hdr(16'hb5f3, `SPD_CMD_EXT);
        txb[2] = {3'h2, `SPD_CMD_EXT, 2'b00};
        txb[3] = {3'h5, `SPD_CMD_READ_WS, 2'b00};
        txb[4] = `SPD_WAIT_BYTE;
        txb[5] = 8'h00;
        txb[6] = `SPD_WAIT_BYTE;
        run(7);
        check(rxb[2] === EV[23:16] && rxb[3] === EV[23:16], "ext");
        check(rxb[5] === md(16'hb5f3), "ext read 0");
        check(rxb[6] === md(16'hb5f4), "ext read 1");
        check(errCnt == e0, "read flagged");
    endtask : t_ext
    task automatic t_status(input logic exp);
        serialCfg <= 8'h04;
        apb(1'b1, `SPD_HOST_SEL, 32'h1);
        repeat (8) @(posedge clk);
        apb(1'b0, `SPD_HOST_RX, 32'h0);
        check(r[11] === exp, "status level");
        apb(1'b1, `SPD_HOST_SEL, 32'h0);
        repeat (8) @(posedge clk);
        serialCfg <= 8'h00;
    endtask : t_status
    task automatic t_short();
        int e0;
        e0 = errCnt;
        hdr(16'he005, `SPD_CMD_READ);
        txb[2] = 8'h00;
        txb[3] = 8'h00;
        run(4);
        check(rxb[2] === md(16'h0005), "short read 0");
        check(rxb[3] === md(16'h0006), "short read 1");
        check(errCnt == e0 + 1, "open read not flagged");
    endtask : t_short
    task automatic t_nop();
        logic [2:0] codes [4] = '{3'h0, 3'h1, 3'h5, 3'h7};
        int w0;
        w0 = wrCnt;
        foreach (codes[k]) begin
            hdr(16'h0400, codes[k]);
            txb[2] = 8'h99;
            run(3);
        end
        check(wrCnt == w0 && mem[16'h0400] === 8'h00, "nop wrote");
    endtask : t_nop
    task automatic t_off();
        portType <= 8'h00;
        repeat (8) @(posedge clk);
        apb(1'b0, `SPD_HOST_RX, 32'h0);
        check(r[10] === 1'b0, "loaded while off");
        hdr(16'h0401, `SPD_CMD_WRITE);
        txb[2] = 8'h77;
        run(3);
        check(mem[16'h0401] === md(16'h0401), "write while off");
        portType <= `SPD_PORT_TYPE_SERIAL;
        repeat (8) @(posedge clk);
        apb(1'b0, `SPD_HOST_RX, 32'h0);
        check(r[10] === 1'b1, "not loaded");
    endtask : t_off
    task automatic t_irq();
        apb(1'b0, `SPD_HOST_RX, 32'h0);
        check(r[9] === 1'b0, "irq idle with events");
        evMask <= 24'h000000;
        repeat (16) @(posedge clk);
        apb(1'b0, `SPD_HOST_RX, 32'h0);
        check(r[9] === 1'b1, "irq with all masked");
        serialCfg <= 8'h10;
        repeat (16) @(posedge clk);
        apb(1'b0, `SPD_HOST_RX, 32'h0);
        check(r[9] === 1'b0, "irq polarity");
        serialCfg <= 8'h00;
        apb(1'b1, 8'h10, 32'h0);
        check(perr === 1'b1, "unmapped accepted");
        apb(1'b0, `SPD_HOST_CFG, 32'h0);
        check(perr === 1'b0 && r[15:0] === 16'h0800, "cfg readback");
    endtask : t_irq
    initial begin
        #1_000_000;
        mismatches++;
        end_of_test();
    end
    initial begin
        srst = 1'b1;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        portType = `SPD_PORT_TYPE_SERIAL;
        serialCfg = 8'h00;
        cfgMemLoaded = 1'b1;
        evMask = 24'hffffff;
        {wrCnt, errCnt, mismatches, samples_checked} = '0;
        for (int i = 0; i < 65536; i++) mem[i] = md(i[15:0]);
        mem[16'h0400] = 8'h00;
        repeat (5) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        apb(1'b1, `SPD_HOST_CFG, 32'h0000_0800);
        repeat (4) @(posedge clk);
        t_write();
        t_status(1'b1);
        t_ext();
        t_short();
        t_status(1'b0);
        t_nop();
        t_off();
        t_irq();
        end_of_test();
    end
endmodule : spd_tb
